// [src/crs_pkg.sv]
// package of constants for the cpu reset sequencer
package crs_pkg;
   localparam int unsigned RST_MIN_CYCLES = 10;
   localparam logic [3:0] RST_CNT_W_MAX = 4'ha;
   localparam logic [23:0] VEC_ADDR_LO = 24'hffff00;
   localparam logic [23:0] VEC_ADDR_MID = 24'hffff01;
   localparam logic [23:0] VEC_ADDR_HI = 24'hffff02;
   localparam logic [31:0] SSP_RESET = 32'h00000100;
   localparam logic [2:0] IML_RESET = 3'h7;
   localparam logic WIDE_RESET = 1'h1;
   localparam logic [2:0] RBP_RESET = 3'h0;
   localparam logic [1:0] CLK_DIV_LAST = 2'h3;
   localparam logic [3:0] ADDR_START_DLY = 4'ha;
   localparam int unsigned IO_REG_W = 8;
   localparam logic [7:0] IO_REG_RESET = 8'h00;
   localparam int unsigned PORT_W = 8;

   typedef enum logic [2:0] {
      ST_HOLD = 3'h0,
      ST_VEC0 = 3'h1,
      ST_VEC1 = 3'h2,
      ST_VEC2 = 3'h3,
      ST_WAIT = 3'h4,
      ST_RUN = 3'h5
   } crs_state_t;
endpackage

// [src/crs_cpu_reset_sequencer.sv]
// reset sequencing for the cpu core: vector fetch, status init, clock out, nmi edge
// Summary of operation
// - program counter loads bytewise from reset vector
// - system stack pointer set to 100h
// - interrupt mask level set to seven
// - wide-mode flag set to one
// - register bank pointer cleared to zero
// - fetch starts at loaded program counter
// - other cpu registers keep their value
// - internal io registers return to init
// - all ports revert to general-purpose mode
// - clock output held high in reset
// - clock output is oscillator divided four
// - nmi on falling or both edges
// - bus width strap sampled at release
// - address outputs start tenth cycle after release
module crs_cpu_reset_sequencer
   import crs_pkg::*;
(
   // clock and power-on reset
   input wire logic core_clk,
   input wire logic rst_n,
   // pins
   input wire logic reset_pin_n,
   input wire logic nmi_pin,
   input wire logic bus_width_strap,
   output logic clk_out,
   // vector fetch port
   output logic vec_rd,
   output logic [23:0] vec_addr,
   input wire logic [7:0] vec_data,
   // cpu control
   input wire logic nmi_both_edges,
   input wire logic sr_wr,
   input wire logic [2:0] sr_wr_iml,
   input wire logic [2:0] sr_wr_rbp,
   input wire logic sr_wr_wide,
   input wire logic ssp_wr,
   input wire logic [31:0] ssp_wr_data,
   input wire logic io_wr,
   input wire logic [7:0] io_wr_data,
   input wire logic port_mode_wr,
   input wire logic [7:0] port_mode_wr_data,
   input wire logic nmi_ack,
   // cpu state
   output logic cpu_run,
   output logic fetch_start,
   output logic addr_out_en,
   output logic [23:0] program_counter,
   output logic [31:0] system_stack_pointer,
   output logic [2:0] interrupt_mask_level,
   output logic [2:0] register_bank_pointer,
   output logic wide_mode,
   output logic [7:0] io_reg,
   output logic [7:0] port_periph_mode,
   output logic bus_8bit,
   output logic nmi_req,
   output logic sys_reset_active
);

   typedef struct packed {
      // pin synchronisers
      logic rs0;
      logic rs1;
      logic nm0;
      logic nm1;
      logic nm2;
      logic bw0;
      logic bw1;
      // reset width filter
      logic [3:0] low_cnt;
      logic accepted;
      // sequencing and clock out
      crs_state_t st;
      logic [1:0] div;
      logic clk_o;
      logic [3:0] dly;
      logic addr_en;
      logic fstart;
      // cpu state
      logic [23:0] pc;
      logic [31:0] ssp;
      logic [2:0] iml;
      logic [2:0] rbp;
      logic wide;
      logic [7:0] io;
      logic [7:0] pmode;
      // strap and nmi
      logic b8;
      logic nmi;
   } crs_regs_t;

   // power-on leaves the core in accepted reset until the pin is seen high
   localparam crs_regs_t Q_RESET = '{
      rs0: 1'b0,
      rs1: 1'b0,
      // nmi sync starts at the idle pin level, so release shows no false edge
      nm0: 1'b1,
      nm1: 1'b1,
      nm2: 1'b1,
      bw0: 1'b0,
      bw1: 1'b0,
      low_cnt: 4'h0,
      accepted: 1'b1,
      st: ST_HOLD,
      div: 2'h0,
      clk_o: 1'b1,
      dly: 4'h0,
      addr_en: 1'b0,
      fstart: 1'b0,
      pc: 24'h000000,
      ssp: SSP_RESET,
      iml: IML_RESET,
      rbp: RBP_RESET,
      wide: WIDE_RESET,
      io: IO_REG_RESET,
      pmode: 8'h00,
      b8: 1'b0,
      nmi: 1'b0
   };

   // the divided clock flips on every odd phase, giving core_clk / 4
   function automatic logic div_flip(logic [1:0] phase);
      return phase == CLK_DIV_LAST || phase == 2'h1;
   endfunction

   // both-edge mode lets a released line request as well
   function automatic logic nmi_edge(logic older, logic newer, logic both);
      logic fall;
      logic rise;
      fall = older && !newer;
      rise = !older && newer;
      return fall || (both && rise);
   endfunction

   // one byte lane of the program counter per vector read
   function automatic logic [23:0] vec_lane(logic [23:0] pc, logic [1:0] k, logic [7:0] b);
      logic [23:0] n;
      n = pc;
      n[{k, 3'h0} +: 8] = b;
      return n;
   endfunction

   // saturating count, so a long low period never wraps into a second accept
   function automatic logic [3:0] sat_inc(logic [3:0] v, logic [3:0] top);
      logic [3:0] n;
      n = v;
      if (v != top) begin
         n = v + 4'h1;
      end
      return n;
   endfunction

   crs_regs_t q;
   crs_regs_t d;

   always_comb begin
      d = q;
      d.fstart = 1'b0;
      d.rs0 = reset_pin_n;
      d.rs1 = q.rs0;
      d.nm0 = nmi_pin;
      d.nm1 = q.nm0;
      d.nm2 = q.nm1;
      d.bw0 = bus_width_strap;
      d.bw1 = q.bw0;
      // nmi edge detection, set wins over ack
      if (nmi_ack) begin
         d.nmi = 1'b0;
      end
      if (nmi_edge(q.nm2, q.nm1, nmi_both_edges)) begin
         d.nmi = 1'b1;
      end
      // count the synchronised low period; short glitches never accept
      if (!q.rs1) begin
         d.low_cnt = sat_inc(q.low_cnt, RST_CNT_W_MAX);
         if (q.low_cnt == RST_CNT_W_MAX - 4'h1) begin
            d.accepted = 1'b1;
         end
      end else begin
         d.low_cnt = 4'h0;
      end
      // divided clock out, held high while in reset
      d.div = q.div + 2'h1;
      if (div_flip(q.div)) begin
         d.clk_o = ~q.clk_o;
      end
      if (d.accepted) begin
         // reset state held for as long as the pin stays low
         d.st = ST_HOLD;
         d.div = 2'h0;
         d.clk_o = 1'b1;
         d.ssp = SSP_RESET;
         d.iml = IML_RESET;
         d.wide = WIDE_RESET;
         d.rbp = RBP_RESET;
         d.io = IO_REG_RESET;
         d.pmode = '0;
         d.addr_en = 1'b0;
         d.dly = 4'h0;
         d.nmi = 1'b0;
         // other cpu registers untouched here
         if (q.rs1) begin
            d.accepted = 1'b0;
            d.b8 = q.bw1;
            d.st = ST_VEC0;
         end
      end else begin
         case (q.st)
            // only reached from a broken state code; never lock up
            ST_HOLD: d.st = ST_RUN;
            ST_VEC0: begin
               d.pc = vec_lane(q.pc, 2'h0, vec_data);
               d.st = ST_VEC1;
            end
            ST_VEC1: begin
               d.pc = vec_lane(q.pc, 2'h1, vec_data);
               d.st = ST_VEC2;
            end
            ST_VEC2: begin
               d.pc = vec_lane(q.pc, 2'h2, vec_data);
               d.st = ST_WAIT;
            end
            ST_WAIT: begin
               d.dly = sat_inc(q.dly, ADDR_START_DLY);
               // release counted from the synchronised high, vector reads included
               if (q.dly == ADDR_START_DLY - 4'h4) begin
                  d.addr_en = 1'b1;
                  d.fstart = 1'b1;
                  d.st = ST_RUN;
               end
            end
            ST_RUN: begin
               // software writes; narrow mode unsupported so wide stays set
               if (sr_wr) begin
                  d.iml = sr_wr_iml;
                  d.rbp = sr_wr_rbp;
                  d.wide = sr_wr_wide | WIDE_RESET;
               end
               if (ssp_wr) begin
                  d.ssp = ssp_wr_data;
               end
               if (io_wr) begin
                  d.io = io_wr_data;
               end
               if (port_mode_wr) begin
                  d.pmode = port_mode_wr_data;
               end
            end
            default: d.st = ST_HOLD;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         q <= Q_RESET;
      end else begin
         q <= d;
      end
   end

   // the vector port is zero-wait: each byte is taken on the edge ending its cycle
   always_comb begin
      vec_rd = 1'b0;
      vec_addr = VEC_ADDR_LO;
      case (q.st)
         ST_VEC0: begin
            vec_rd = !q.accepted;
            vec_addr = VEC_ADDR_LO;
         end
         ST_VEC1: begin
            vec_rd = !q.accepted;
            vec_addr = VEC_ADDR_MID;
         end
         ST_VEC2: begin
            vec_rd = !q.accepted;
            vec_addr = VEC_ADDR_HI;
         end
         default: vec_rd = 1'b0;
      endcase
   end

   // cpu_run and the read strobe also look at accepted, so a new reset stops them at once
   assign clk_out = q.clk_o;
   assign cpu_run = (q.st == ST_RUN) && !q.accepted;
   assign fetch_start = q.fstart;
   assign addr_out_en = q.addr_en;
   assign program_counter = q.pc;
   assign system_stack_pointer = q.ssp;
   assign interrupt_mask_level = q.iml;
   assign register_bank_pointer = q.rbp;
   assign wide_mode = q.wide;
   assign io_reg = q.io;
   assign port_periph_mode = q.pmode;
   assign bus_8bit = q.b8;
   assign nmi_req = q.nmi;
   assign sys_reset_active = q.accepted;

endmodule

// [test/crs_monitor.sv]
// checker on the reset sequencer ports
module crs_monitor
   import crs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // watched
   input wire logic reset_pin_n,
   input wire logic clk_out,
   input wire logic vec_rd,
   input wire logic [23:0] vec_addr,
   input wire logic cpu_run,
   input wire logic fetch_start,
   input wire logic addr_out_en,
   input wire logic [2:0] interrupt_mask_level,
   input wire logic wide_mode,
   input wire logic sys_reset_active
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   clk_hi_a: assert property ($past(sys_reset_active) && sys_reset_active |-> clk_out)
      else $error("clk low in reset");
   clk_div_a: assert property (
      cpu_run && $past(cpu_run, 2) |-> clk_out != $past(clk_out, 2)) else $error("clk not div4");
   vec_order_a: assert property ($rose(vec_rd) |-> vec_addr == VEC_ADDR_LO ##1
      vec_rd && vec_addr == VEC_ADDR_MID ##1 vec_rd && vec_addr == VEC_ADDR_HI ##1 !vec_rd)
      else $error("vector order");
   fetch_dly_a: assert property (
      $rose(vec_rd) |-> ##10 fetch_start && addr_out_en && cpu_run) else $error("fetch late");
   fetch_one_a: assert property (fetch_start |=> !fetch_start && addr_out_en)
      else $error("fetch pulse");
   iml_init_a: assert property ($past(sys_reset_active) && sys_reset_active |->
      interrupt_mask_level == IML_RESET) else $error("mask not seven");
   wide_set_a: assert property (wide_mode) else $error("wide cleared");
   rst_width_a: assert property ($rose(sys_reset_active) |->
      !$past(reset_pin_n, 3) && !$past(reset_pin_n, 10)) else $error("short reset taken");
   cover property ($rose(sys_reset_active));
   cover property (fetch_start);
   cover property (vec_rd && vec_addr == VEC_ADDR_HI);
endmodule

// [test/crs_vec_rom.sv]
// vector rom on the far side of the fetch port
module crs_vec_rom (
   // fetch port
   input wire logic core_clk,
   input wire logic vec_rd,
   input wire logic [23:0] vec_addr,
   output logic [7:0] vec_data,
   // contents
   input wire logic [23:0] vector
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] junk_q = 8'h5a;
   // idle bus moves every cycle so a stray sample never matches by luck
   always @(posedge core_clk) junk_q <= junk_q + 8'h3b;
   assign vec_data = vec_rd && vec_addr[23:2] == 22'h3fffc0 ?
      vector[{vec_addr[1:0], 3'h0} +: 8] : junk_q;
endmodule

// [test/crs_cpu_reset_sequencer_test.sv]
// self-checking bench for the reset sequencer
module crs_cpu_reset_sequencer_test
   import crs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // pins are driven both ways by the bench, never left to a pull-up
   logic core_clk = 1'b0, rst_n = 1'b0, reset_pin_n = 1'b1, nmi_pin = 1'b1, nmi_ack = 1'b0;
   logic bus_width_strap = 1'b0, nmi_both_edges = 1'b0, sr_wr_wide = 1'b1;
   logic sr_wr = 1'b0, ssp_wr = 1'b0, io_wr = 1'b0, port_mode_wr = 1'b0;
   logic [2:0] sr_wr_iml = 3'h0, sr_wr_rbp = 3'h0, interrupt_mask_level, register_bank_pointer;
   logic [31:0] ssp_wr_data = 32'h0, system_stack_pointer, r;
   logic [7:0] io_wr_data = 8'h0, port_mode_wr_data = 8'h0, vec_data, io_reg, port_periph_mode;
   logic [23:0] vec = 24'h0, vec_addr, program_counter;
   logic clk_out, vec_rd, cpu_run, fetch_start, addr_out_en, wide_mode, bus_8bit, nmi_req;
   logic sys_reset_active;
   int miscompares = 0, checks_done = 0, seed = 605, cyc = 0;
   crs_cpu_reset_sequencer u_dut (.core_clk, .rst_n, .reset_pin_n, .nmi_pin, .bus_width_strap,
      .clk_out, .vec_rd, .vec_addr, .vec_data, .nmi_both_edges, .sr_wr, .sr_wr_iml, .sr_wr_rbp,
      .sr_wr_wide, .ssp_wr, .ssp_wr_data, .io_wr, .io_wr_data, .port_mode_wr, .port_mode_wr_data,
      .nmi_ack, .cpu_run, .fetch_start, .addr_out_en, .program_counter, .system_stack_pointer,
      .interrupt_mask_level, .register_bank_pointer, .wide_mode, .io_reg, .port_periph_mode,
      .bus_8bit, .nmi_req, .sys_reset_active);
   crs_vec_rom u_rom (.core_clk, .vec_rd, .vec_addr, .vec_data, .vector(vec));
   initial forever #2.5 core_clk = ~core_clk;
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic conclude;
      $display("checks %0d mismatches %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic pin_low(int n);
      reset_pin_n <= 1'b0;
      repeat (n - 1) @(posedge core_clk);
      @(posedge core_clk) reset_pin_n <= 1'b1;
   endtask
   task automatic wait_fetch;
      repeat (40) begin
         @(posedge core_clk) #1;
         if (fetch_start === 1'b1) break;
      end
      chk("fetch start", 32'h1, 32'(fetch_start));
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         conclude();
      end
   end
   initial begin
      r = $random(seed);
      vec <= r[23:0];
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      // power-on release runs its own vector fetch before any pin reset
      wait_fetch();
      chk("boot pc", 32'(vec), 32'(program_counter));
      $display("power-on test done");
      for (int i = 0; i < 6; i++) begin
         @(posedge core_clk);
         r = $random(seed);
         vec <= r[23:0];
         bus_width_strap <= i[0];
         pin_low(10 + i);
         wait_fetch();
         chk("pc", 32'(vec), 32'(program_counter));
         chk("ssp", SSP_RESET, system_stack_pointer);
         chk("init", {9'h0, IML_RESET, RBP_RESET, 1'b1, IO_REG_RESET, 8'h00},
            {9'h0, interrupt_mask_level, register_bank_pointer, wide_mode, io_reg, port_periph_mode});
         r = $random(seed);
         @(posedge core_clk);
         {sr_wr, ssp_wr, io_wr, port_mode_wr} <= 4'hf;
         {port_mode_wr_data, io_wr_data, sr_wr_rbp, sr_wr_iml} <= r[21:0];
         ssp_wr_data <= r;
         nmi_both_edges <= i[0];
         // strap moves after release and must not be taken again
         bus_width_strap <= ~i[0];
         @(posedge core_clk) {sr_wr, ssp_wr, io_wr, port_mode_wr} <= 4'h0;
         @(posedge core_clk) nmi_pin <= 1'b0;
         #1 chk("written", 32'(r[21:0]), 32'({port_periph_mode, io_reg,
            register_bank_pointer, interrupt_mask_level}));
         chk("ssp written", r, system_stack_pointer);
         chk("strap", 32'(i[0]), 32'(bus_8bit));
         repeat (5) @(posedge core_clk);
         #1 chk("nmi fall", 32'h1, 32'(nmi_req));
         @(posedge core_clk) nmi_ack <= 1'b1;
         @(posedge core_clk) nmi_ack <= 1'b0;
         nmi_pin <= 1'b1;
         repeat (5) @(posedge core_clk);
         #1 chk("nmi rise", 32'(i[0]), 32'(nmi_req));
         @(posedge core_clk) nmi_ack <= 1'b1;
         @(posedge core_clk) nmi_ack <= 1'b0;
         pin_low(9);
         repeat (20) @(posedge core_clk);
         #1 chk("glitch", 32'({1'b1, r[13:6]}), 32'({cpu_run, io_reg}));
         $display("test %0d done", i);
      end
      conclude();
   end
endmodule
bind crs_cpu_reset_sequencer crs_monitor u_mon (.core_clk, .rst_n, .reset_pin_n, .clk_out,
   .vec_rd, .vec_addr, .cpu_run, .fetch_start, .addr_out_en, .interrupt_mask_level, .wide_mode,
   .sys_reset_active);
